/* rtl/ssf_pkg.sv */
package ssf_pkg;

  // ---------------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------------
  localparam int          SSF_BYTE_W    = 8;
  localparam int          SSF_CNT_W     = 3;
  localparam logic [2:0]  SSF_CNT_LAST  = 3'h7;
  localparam logic [2:0]  SSF_CNT_RST   = 3'h0;
  localparam logic [7:0]  SSF_BYTE_RST  = 8'h00;
  localparam logic        SSF_PIN_IDLE  = 1'b1;

  // ---------------------------------------------------------------------
  // Shift register occupancy
  // ---------------------------------------------------------------------
  typedef enum logic [0:0] {
    SSF_SH_IDLE = 1'b0,
    SSF_SH_BUSY = 1'b1
  } ssf_shift_t;

endpackage : ssf_pkg

/* rtl/ssf_status.sv */
// What this block does
// - The slave-selected flag reads one while the select pin is low.
// - The slave-selected flag reads zero while the select pin is high.
// - The slave-selected flag follows a filtered copy of the select pin.
// - The raw pin level output shows the select pin level after the two-stage synchroniser.
// - The raw pin level output has no glitch filter.
// - Shift-empty rises once a byte is done and nothing waits to move.
// - Shift-empty falls on a buffer-to-shifter load or on an SCK toggle.
// - Shift-empty reads one whenever the port is master.
// - Receive-empty rises once software has read the buffer, none newer.
// - Receive-empty is zero while an unread received byte is held, unless the port is master.
// - Receive-empty reads one whenever the port is master.
module ssf_status
  import ssf_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        sck_clk,
  input  wire logic                        mosi,
  input  wire logic                        nss_n,
  input  wire logic                        master_mode,
  input  wire logic [ssf_pkg::SSF_BYTE_W-1:0] tx_data,
  input  wire logic                        tx_write,
  input  wire logic                        rx_read,
  output logic      [ssf_pkg::SSF_BYTE_W-1:0] rx_data,
  output logic                             tx_ready,
  output logic                             miso,
  output logic                             miso_oe_n,
  output logic                             slave_selected_flag,
  output logic                             select_pin_raw_level,
  output logic                             shift_empty_flag,
  output logic                             receive_empty_flag
);
  import ssf_pkg::*;

  // ---------------------------------------------------------------------
  // Link side, SCK domain (mode: launch on rise, sample on fall)
  // ---------------------------------------------------------------------
  logic [SSF_CNT_W-1:0]  tx_cnt_q;
  logic [SSF_CNT_W-1:0]  rx_cnt_q;
  logic [SSF_BYTE_W-1:0] tx_sh_q;
  logic [SSF_BYTE_W-1:0] rx_sh_q;
  logic [SSF_BYTE_W-1:0] rx_word_q;
  logic                  rx_tgl_q;
  logic                  miso_q;
  logic [SSF_BYTE_W-1:0] tx_load_q;

  // Select high aborts a partial byte; counters start fresh next frame
  always_ff @(posedge sck_clk or negedge rstn or posedge nss_n) begin
    if (!rstn || nss_n) begin
      tx_cnt_q <= SSF_CNT_RST;
    end else begin
      tx_cnt_q <= tx_cnt_q + 3'h1;
    end
  end

  // Loaded word is held static in the system domain while a byte runs
  always_ff @(posedge sck_clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh_q <= SSF_BYTE_RST;
      miso_q  <= 1'b0;
    end else if (tx_cnt_q == SSF_CNT_RST) begin
      miso_q  <= tx_load_q[SSF_BYTE_W-1];
      tx_sh_q <= {tx_load_q[SSF_BYTE_W-2:0], 1'b0};
    end else begin
      miso_q  <= tx_sh_q[SSF_BYTE_W-1];
      tx_sh_q <= {tx_sh_q[SSF_BYTE_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge sck_clk or negedge rstn or posedge nss_n) begin
    if (!rstn || nss_n) begin
      rx_cnt_q <= SSF_CNT_RST;
      rx_sh_q  <= SSF_BYTE_RST;
    end else begin
      rx_cnt_q <= rx_cnt_q + 3'h1;
      rx_sh_q  <= {rx_sh_q[SSF_BYTE_W-2:0], mosi};
    end
  end

  // Toggle survives select changes so no finished byte is lost
  always_ff @(negedge sck_clk or negedge rstn) begin
    if (!rstn) begin
      rx_word_q <= SSF_BYTE_RST;
      rx_tgl_q  <= 1'b0;
    end else if (!nss_n && rx_cnt_q == SSF_CNT_LAST) begin
      rx_word_q <= {rx_sh_q[SSF_BYTE_W-2:0], mosi};
      rx_tgl_q  <= ~rx_tgl_q;
    end
  end

  // ---------------------------------------------------------------------
  // Synchronisers into the system clock
  // ---------------------------------------------------------------------
  logic nss_m_q;
  logic nss_s_q;
  logic nss_h_q;
  logic nss_filt_q;
  logic sck_m_q;
  logic sck_s_q;
  logic sck_h_q;
  logic tgl_m_q;
  logic tgl_s_q;
  logic tgl_h_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      nss_m_q <= SSF_PIN_IDLE;
      nss_s_q <= SSF_PIN_IDLE;
      nss_h_q <= SSF_PIN_IDLE;
    end else begin
      nss_m_q <= nss_n;
      nss_s_q <= nss_m_q;
      nss_h_q <= nss_s_q;
    end
  end

  // Two equal synced samples before the filtered level moves
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      nss_filt_q <= SSF_PIN_IDLE;
    end else if (nss_s_q == nss_h_q) begin
      nss_filt_q <= nss_s_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_h_q <= 1'b0;
      tgl_m_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_h_q <= 1'b0;
    end else begin
      sck_m_q <= sck_clk;
      sck_s_q <= sck_m_q;
      sck_h_q <= sck_s_q;
      tgl_m_q <= rx_tgl_q;
      tgl_s_q <= tgl_m_q;
      tgl_h_q <= tgl_s_q;
    end
  end

  logic sck_edge;
  logic byte_done;
  logic deselect;
  assign sck_edge  = sck_s_q ^ sck_h_q;
  assign byte_done = tgl_s_q ^ tgl_h_q;
  assign deselect  = nss_s_q & nss_h_q & ~nss_filt_q;

  // ---------------------------------------------------------------------
  // Transmit buffer and shift register occupancy
  // ---------------------------------------------------------------------
  logic                  tx_full_q;
  logic [SSF_BYTE_W-1:0] tx_buf_q;
  ssf_shift_t            shift_q;
  logic                  load;

  // Load only into an idle shifter; a running byte is never overwritten
  assign load = tx_full_q && (shift_q == SSF_SH_IDLE);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_full_q <= 1'b0;
      tx_buf_q  <= SSF_BYTE_RST;
    end else if (tx_write && (!tx_full_q || load)) begin
      tx_full_q <= 1'b1;
      tx_buf_q  <= tx_data;
    end else if (load) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_load_q <= SSF_BYTE_RST;
    end else if (load) begin
      tx_load_q <= tx_buf_q;
    end
  end

  // Set wins, except the closing SCK edge, which lands with byte_done
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= SSF_SH_IDLE;
    end else if (load || (sck_edge && !byte_done)) begin
      shift_q <= SSF_SH_BUSY;
    end else if (byte_done || deselect) begin
      shift_q <= SSF_SH_IDLE;
    end
  end

  // ---------------------------------------------------------------------
  // Receive buffer
  // ---------------------------------------------------------------------
  logic                  rx_full_q;

  // Word is static for seven SCK edges after the toggle, so safe to copy
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_full_q <= 1'b0;
      rx_data   <= SSF_BYTE_RST;
    end else if (byte_done) begin
      rx_full_q <= 1'b1;
      rx_data   <= rx_word_q;
    end else if (rx_read) begin
      rx_full_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Status outputs, all registered
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slave_selected_flag  <= 1'b0;
      select_pin_raw_level <= SSF_PIN_IDLE;
      shift_empty_flag     <= 1'b1;
      receive_empty_flag   <= 1'b1;
      tx_ready             <= 1'b0;
      miso_oe_n            <= 1'b1;
      miso                 <= 1'b0;
    end else begin
      slave_selected_flag  <= ~nss_filt_q;
      select_pin_raw_level <= nss_s_q;
      shift_empty_flag     <= master_mode ||
                              (shift_q == SSF_SH_IDLE &&
                               !tx_full_q && !byte_done);
      receive_empty_flag   <= master_mode || !rx_full_q;
      tx_ready             <= !tx_full_q;
      miso_oe_n            <= nss_filt_q;
      miso                 <= miso_q;
    end
  end

endmodule : ssf_status

/* bench/ssf_status_chk.sv */
module ssf_status_chk (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sck_clk,
  input wire logic nss_n,
  input wire logic master_mode,
  input wire logic rx_read,
  input wire logic slave_selected_flag,
  input wire logic select_pin_raw_level,
  input wire logic shift_empty_flag,
  input wire logic receive_empty_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Status flag checks
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_SEL_LOW: assert property (!nss_n [*6] |-> slave_selected_flag)
    else $error("slave flag low while selected");
  AST_SEL_HIGH: assert property (nss_n [*6] |-> !slave_selected_flag)
    else $error("slave flag high while deselected");
  AST_SEL_GLITCH: assert property (
    !slave_selected_flag && $fell(nss_n) ##1 $rose(nss_n)
    |-> ##1 !slave_selected_flag [*6])
    else $error("slave flag moved on a glitch");
  AST_RAW_LEVEL: assert property (nss_n [*4] |=> select_pin_raw_level)
    else $error("raw level not high");
  AST_RAW_GLITCH: assert property ($fell(nss_n) ##1 $rose(nss_n)
    |-> ##[1:3] !select_pin_raw_level)
    else $error("raw level missed a glitch");
  AST_SHIFT_SCK: assert property (!master_mode && !nss_n &&
    $changed(sck_clk) |-> ##[0:5] !shift_empty_flag)
    else $error("shift empty stayed high on sck");
  AST_SHIFT_MST: assert property (master_mode [*2] |-> shift_empty_flag)
    else $error("shift empty low in master mode");
  AST_RX_READ: assert property (rx_read && !master_mode
    |-> ##[1:3] receive_empty_flag)
    else $error("receive empty not set by read");
  AST_RX_MST: assert property (
    master_mode [*2] |-> receive_empty_flag)
    else $error("receive empty low in master mode");
endmodule : ssf_status_chk

bind ssf_status ssf_status_chk chk_i (
  .sys_clk              (sys_clk),
  .rstn                 (rstn),
  .sck_clk              (sck_clk),
  .nss_n                (nss_n),
  .master_mode          (master_mode),
  .rx_read              (rx_read),
  .slave_selected_flag  (slave_selected_flag),
  .select_pin_raw_level (select_pin_raw_level),
  .shift_empty_flag     (shift_empty_flag),
  .receive_empty_flag   (receive_empty_flag)
);

/* bench/ssf_master_model.sv */
module ssf_master_model (
  input  wire logic sys_clk,
  input  wire logic miso_line,
  output logic      sck_clk,
  output logic      mosi,
  output logic      nss_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow link: sck must span at least four sys_clk periods
  localparam time HALF = 60ns;
  logic [7:0] got;
  initial begin
    sck_clk = 1'b0;
    mosi    = 1'b0;
    nss_n   = 1'b1;
  end
  task automatic sel(input logic lvl);
    @(posedge sys_clk);
    nss_n <= lvl;
  endtask : sel
  task automatic xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #HALF sck_clk = 1'b1;
      mosi = b[i];
      #HALF sck_clk = 1'b0;
      got[i] = miso_line;
    end
    // Released line must not keep the last bit
    #HALF mosi = ~mosi;
  endtask : xfer
endmodule : ssf_master_model

/* bench/tb_ssf_status.sv */
module tb_ssf_status;
  timeunit 1ns;
  timeprecision 1ps;
  import ssf_pkg::*;
  logic                  sys_clk, rstn, master_mode, tx_write, rx_read;
  logic                  sck_clk, mosi, nss_n, tx_ready, miso, miso_oe_n;
  logic                  slave_selected_flag, select_pin_raw_level;
  logic                  shift_empty_flag, receive_empty_flag;
  logic [SSF_BYTE_W-1:0] tx_data, rx_data;
  int                    error_cnt = 0, compares = 0, cyc = 0;
  // Pull-up on the shared line when released
  wire                   miso_line = miso_oe_n ? 1'b1 : miso;
  ssf_status uut (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .sck_clk              (sck_clk),
    .mosi                 (mosi),
    .nss_n                (nss_n),
    .master_mode          (master_mode),
    .tx_data              (tx_data),
    .tx_write             (tx_write),
    .rx_read              (rx_read),
    .rx_data              (rx_data),
    .tx_ready             (tx_ready),
    .miso                 (miso),
    .miso_oe_n            (miso_oe_n),
    .slave_selected_flag  (slave_selected_flag),
    .select_pin_raw_level (select_pin_raw_level),
    .shift_empty_flag     (shift_empty_flag),
    .receive_empty_flag   (receive_empty_flag)
  );
  ssf_master_model m (.sys_clk, .miso_line, .sck_clk, .mosi, .nss_n);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wt
  initial begin
    rstn = 1'b0; master_mode = 1'b0; tx_write = 1'b0;
    rx_read = 1'b0; tx_data = 8'h00;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    wt(3);
    chk("sse", 1'b1, shift_empty_flag);
    chk("rxe", 1'b1, receive_empty_flag);
    chk("sel", 1'b0, slave_selected_flag);
    chk("raw", 1'b1, select_pin_raw_level);
    chk("rdy", 1'b1, tx_ready);
    chk("oe", 1'b1, miso_oe_n);
    m.sel(1'b0);
    m.sel(1'b1);
    wt(8);
    chk("sel_glitch", 1'b0, slave_selected_flag);
    m.sel(1'b0);
    wt(8);
    chk("sel_lo", 1'b1, slave_selected_flag);
    chk("raw_lo", 1'b0, select_pin_raw_level);
    chk("oe_lo", 1'b0, miso_oe_n);
    @(posedge sys_clk);
    tx_data <= 8'h3C;
    tx_write <= 1'b1;
    @(posedge sys_clk);
    tx_write <= 1'b0;
    wt(4);
    chk("sse_load", 1'b0, shift_empty_flag);
    m.xfer(8'hA5);
    wt(8);
    chk("rx_data", 8'hA5, rx_data);
    chk("rxe_full", 1'b0, receive_empty_flag);
    chk("miso", 8'h3C, m.got);
    chk("sse_done", 1'b1, shift_empty_flag);
    // Second byte overwrites the unread one
    @(posedge sys_clk);
    tx_data <= 8'hC3;
    tx_write <= 1'b1;
    @(posedge sys_clk);
    tx_write <= 1'b0;
    wt(4);
    chk("sse_load2", 1'b0, shift_empty_flag);
    m.xfer(8'h5A);
    chk("miso2", 8'hC3, m.got);
    @(posedge sys_clk);
    master_mode <= 1'b1;
    wt(3);
    chk("sse_mst", 1'b1, shift_empty_flag);
    chk("rxe_mst", 1'b1, receive_empty_flag);
    @(posedge sys_clk);
    master_mode <= 1'b0;
    wt(3);
    chk("rxe_back", 1'b0, receive_empty_flag);
    chk("rx_data2", 8'h5A, rx_data);
    @(posedge sys_clk);
    rx_read <= 1'b1;
    @(posedge sys_clk);
    rx_read <= 1'b0;
    wt(3);
    chk("rxe_read", 1'b1, receive_empty_flag);
    m.sel(1'b1);
    wt(8);
    chk("sel_hi", 1'b0, slave_selected_flag);
    chk("sse_idle", 1'b1, shift_empty_flag);
    chk("oe_hi", 1'b1, miso_oe_n);
    end_sim();
  end
endmodule : tb_ssf_status
